// ==== rtl/csf_defs.svh ====
// constants for the cpu status flags low byte
// assumes inclusion by the status flags module and the property checker
`ifndef CSF_DEFS_SVH
`define CSF_DEFS_SVH
`define CSF_ADDR_W 4
`define CSF_ADDR_STATUS 4'h0
`define CSF_ADDR_CORE_CTRL 4'h1
`define CSF_ADDR_INT_CTRL1 4'h2
`define CSF_STATUS_RESET 16'h0000
`define CSF_CORE_CTRL_RESET 16'h0000
`define CSF_INT_CTRL1_RESET 16'h0000
`define CSF_IPL_HI 7
`define CSF_IPL_LO 5
`define CSF_RA_BIT 4
`define CSF_N_BIT 3
`define CSF_OV_BIT 2
`define CSF_Z_BIT 1
`define CSF_C_BIT 0
`define CSF_IPL_EXT_BIT 3
`define CSF_NEST_DIS_BIT 15
`define CSF_IPL_MAX 3'h7
`define CSF_LOW_BYTE_MASK 16'h00ff
`define CSF_EXT_MASK 16'h0008
`define CSF_NEST_MASK 16'h8000
`endif

// ==== rtl/csf_pkg.sv ====
// types for the cpu status flags low byte
// assumes csf_defs.svh is on the include path
package csf_pkg;
	typedef enum logic [1:0] {
		CSF_OP_NONE = 2'h0,
		CSF_OP_ADD = 2'h1,
		CSF_OP_SUB = 2'h3,
		CSF_OP_LOGIC = 2'h2
	} csf_op_t;
	typedef enum logic [1:0] {
		CSF_RPT_IDLE = 2'h0,
		CSF_RPT_RUN = 2'h1
	} csf_rpt_t;
endpackage

// ==== rtl/csf_alu_flags.sv ====
// flag arithmetic for one 16-bit alu result
// assumes operands and op come from the execution unit on the same clock
`timescale 1ns/1ns
`default_nettype none
module csf_alu_flags
	import csf_pkg::*;
(
	input wire logic [15:0] op_a_i,
	input wire logic [15:0] op_b_i,
	input wire csf_op_t op_i,
	input wire logic zero_prev_i,
	output logic neg_o,
	output logic ovf_o,
	output logic zero_o,
	output logic carry_o
);
	logic [16:0] sum;
	logic [15:0] res;
	logic sub_b;
	always_comb begin
		sub_b = (op_i == CSF_OP_SUB);
		sum = 17'h00000;
		res = 16'h0000;
		case (op_i)
			CSF_OP_ADD: sum = {1'b0, op_a_i} + {1'b0, op_b_i};
			CSF_OP_SUB: sum = {1'b0, op_a_i} + {1'b0, ~op_b_i} + 17'h00001;
			CSF_OP_LOGIC: sum = {1'b0, op_a_i & op_b_i};
			default: sum = 17'h00000;
		endcase
		res = sum[15:0];
		neg_o = res[15]; // RQ7
		ovf_o = (op_i == CSF_OP_ADD || op_i == CSF_OP_SUB) &&
			(op_a_i[15] == (op_b_i[15] ^ sub_b)) && (res[15] != op_a_i[15]); // RQ8
		zero_o = (op_i == CSF_OP_NONE) ? zero_prev_i : (res == 16'h0000); // RQ9
		carry_o = (op_i == CSF_OP_LOGIC) ? 1'b0 : sum[16]; // RQ10
	end
endmodule // csf_alu_flags
`default_nettype wire

// ==== rtl/csf_status_flags.sv ====
// cpu status register low byte with core control and nesting control
// assumes the execution unit and register port share clk_i
// assumes the interrupt controller reads the priority outputs directly
// each field of the low byte lives in its own flip-flops
//
// Notes on behaviour
// (RQ1) priority level field sits in bits 7 to 5, value n is level n.
// (RQ2) field value 7 blocks all user interrupts.
// (RQ3) extension bit sits above the field, adding 8 to the level.
// (RQ4) extension bit set disables all user interrupts.
// (RQ5) nesting disable set makes the priority field read-only.
// (RQ6) bit 4 is one only while a repeat loop runs.
// (RQ7) bit 3 set for a negative result, cleared otherwise.
// (RQ8) bit 2 set on signed overflow, cleared otherwise.
// (RQ9) bit 1 is sticky zero, cleared by a later non-zero result; the code also sets it on every zero result.
// (RQ10) bit 0 set on carry out of the top bit.
// (RQ11) clear-only bits may be read and cleared by software, never set.
// (RQ12) with nesting enabled, software priority writes take effect at once.
`include "csf_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module csf_status_flags
	import csf_pkg::*;
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [`CSF_ADDR_W-1:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [15:0] rdata_o,
	input wire logic [15:0] op_a_i,
	input wire logic [15:0] op_b_i,
	input wire csf_op_t op_i,
	input wire logic [13:0] rpt_count_i,
	input wire logic rpt_start_i,
	input wire logic [2:0] irq_level_i,
	input wire logic irq_pending_i,
	input wire logic [2:0] exc_level_i,
	input wire logic exc_take_i,
	output logic irq_accept_o,
	output logic [3:0] cpu_priority_o,
	output logic user_irq_disabled_o,
	output logic repeat_loop_active_o
);
	logic [2:0] prio_field_r;
	logic flag_neg_r;
	logic flag_ovf_r;
	logic flag_zero_r;
	logic flag_carry_r;
	logic ext_bit_r;
	logic nest_dis_r;
	logic [13:0] rpt_cnt_r;
	csf_rpt_t rpt_state_r;
	logic [15:0] rdata_r;
	logic rpt_running;
	logic rpt_last;
	logic [7:0] status_byte;
	logic [15:0] core_ctrl_word;
	logic [15:0] int_ctrl1_word;
	logic neg_w;
	logic ovf_w;
	logic zero_w;
	logic carry_w;
	logic op_live;
	logic wr_status;
	logic wr_core;
	logic wr_int1;
	logic prio_hw_ld;
	logic prio_sw_wr;
	logic priority_extension_bit;
	logic interrupt_nesting_disable;
	logic [2:0] cpu_priority_level_field;
	logic field_at_max;
	logic level_beats_field;

	// register index compare
	function automatic logic hit(
		input logic [`CSF_ADDR_W-1:0] a,
		input logic [`CSF_ADDR_W-1:0] b
	);
		hit = (a == b);
	endfunction

	// one bit of a reset constant
	function automatic logic bit_of(
		input logic [15:0] w,
		input int unsigned pos
	);
		bit_of = w[pos];
	endfunction

	// clear-only update, a zero clears and a one keeps
	function automatic logic clear_only(
		input logic cur,
		input logic wbit
	);
		clear_only = cur & wbit;
	endfunction

	// requested level strictly above the current one
	function automatic logic level_above(
		input logic [2:0] req,
		input logic [2:0] cur
	);
		level_above = (req > cur);
	endfunction

	// low byte of the status register
	function automatic logic [7:0] pack_status(
		input logic [2:0] field,
		input logic ra,
		input logic n,
		input logic ov,
		input logic z,
		input logic c
	);
		pack_status = 8'h00;
		pack_status[`CSF_IPL_HI:`CSF_IPL_LO] = field;
		pack_status[`CSF_RA_BIT] = ra;
		pack_status[`CSF_N_BIT] = n;
		pack_status[`CSF_OV_BIT] = ov;
		pack_status[`CSF_Z_BIT] = z;
		pack_status[`CSF_C_BIT] = c;
	endfunction

	// register read mux, unmapped indexes read zero
	function automatic logic [15:0] read_word(
		input logic [`CSF_ADDR_W-1:0] a,
		input logic [7:0] st,
		input logic [15:0] cc,
		input logic [15:0] ic
	);
		read_word = 16'h0000;
		case (a)
			`CSF_ADDR_STATUS: read_word = {8'h00, st} & `CSF_LOW_BYTE_MASK;
			`CSF_ADDR_CORE_CTRL: read_word = cc;
			`CSF_ADDR_INT_CTRL1: read_word = ic;
			default: read_word = 16'h0000;
		endcase
	endfunction

	assign wr_status = wr_i && hit(addr_i, `CSF_ADDR_STATUS);
	assign wr_core = wr_i && hit(addr_i, `CSF_ADDR_CORE_CTRL);
	assign wr_int1 = wr_i && hit(addr_i, `CSF_ADDR_INT_CTRL1);
	assign op_live = (op_i != CSF_OP_NONE);
	assign prio_hw_ld = exc_take_i;
	assign prio_sw_wr = wr_status && !interrupt_nesting_disable; // RQ5
	assign priority_extension_bit = ext_bit_r;
	assign interrupt_nesting_disable = nest_dis_r;
	assign cpu_priority_level_field = prio_field_r; // RQ1
	assign rpt_running = (rpt_state_r == CSF_RPT_RUN); // RQ6
	assign rpt_last = (rpt_cnt_r == 14'h0000);
	assign field_at_max = (cpu_priority_level_field == `CSF_IPL_MAX); // RQ2
	assign level_beats_field = level_above(irq_level_i, cpu_priority_level_field);
	assign status_byte = pack_status(prio_field_r, rpt_running, flag_neg_r, flag_ovf_r,
		flag_zero_r, flag_carry_r);

	// control words as software sees them
	always_comb begin
		core_ctrl_word = 16'h0000;
		core_ctrl_word[`CSF_IPL_EXT_BIT] = ext_bit_r;
		int_ctrl1_word = 16'h0000;
		int_ctrl1_word[`CSF_NEST_DIS_BIT] = nest_dis_r;
	end

	// flag arithmetic
	csf_alu_flags u_alu (
		.op_a_i(op_a_i),
		.op_b_i(op_b_i),
		.op_i(op_i),
		.zero_prev_i(flag_zero_r),
		.neg_o(neg_w),
		.ovf_o(ovf_w),
		.zero_o(zero_w),
		.carry_o(carry_w)
	);

	// priority field, a hardware load beats a software write
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			prio_field_r <= 3'(`CSF_STATUS_RESET >> `CSF_IPL_LO);
		end else if (prio_hw_ld) begin
			prio_field_r <= exc_level_i;
		end else if (prio_sw_wr) begin // RQ5
			prio_field_r <= wdata_i[`CSF_IPL_HI:`CSF_IPL_LO]; // RQ12
		end
	end

	// negative flag, an op beats a software clear
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			flag_neg_r <= bit_of(`CSF_STATUS_RESET, `CSF_N_BIT);
		end else if (op_live) begin
			flag_neg_r <= neg_w; // RQ7
		end else if (wr_status) begin
			flag_neg_r <= clear_only(flag_neg_r, wdata_i[`CSF_N_BIT]); // RQ11
		end
	end

	// overflow flag, an op beats a software clear
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			flag_ovf_r <= bit_of(`CSF_STATUS_RESET, `CSF_OV_BIT);
		end else if (op_live) begin
			flag_ovf_r <= ovf_w; // RQ8
		end else if (wr_status) begin
			flag_ovf_r <= clear_only(flag_ovf_r, wdata_i[`CSF_OV_BIT]); // RQ11
		end
	end

	// zero flag, set by every zero result, an op beats a software clear
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			flag_zero_r <= bit_of(`CSF_STATUS_RESET, `CSF_Z_BIT);
		end else if (op_live) begin
			flag_zero_r <= zero_w; // RQ9
		end else if (wr_status) begin
			flag_zero_r <= clear_only(flag_zero_r, wdata_i[`CSF_Z_BIT]); // RQ11
		end
	end

	// carry flag, an op beats a software clear
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			flag_carry_r <= bit_of(`CSF_STATUS_RESET, `CSF_C_BIT);
		end else if (op_live) begin
			flag_carry_r <= carry_w; // RQ10
		end else if (wr_status) begin
			flag_carry_r <= clear_only(flag_carry_r, wdata_i[`CSF_C_BIT]); // RQ11
		end
	end

	// priority extension bit in core control
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			ext_bit_r <= bit_of(`CSF_CORE_CTRL_RESET, `CSF_IPL_EXT_BIT);
		end else if (wr_core) begin
			ext_bit_r <= wdata_i[`CSF_IPL_EXT_BIT]; // RQ3
		end
	end

	// nesting disable in interrupt control 1
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			nest_dis_r <= bit_of(`CSF_INT_CTRL1_RESET, `CSF_NEST_DIS_BIT);
		end else if (wr_int1) begin
			nest_dis_r <= wdata_i[`CSF_NEST_DIS_BIT]; // RQ5
		end
	end

	// repeat loop state, runs for count plus one cycles
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			rpt_state_r <= CSF_RPT_IDLE;
		end else begin
			case (rpt_state_r)
				CSF_RPT_IDLE: begin
					if (rpt_start_i) begin
						rpt_state_r <= CSF_RPT_RUN; // RQ6
					end
				end
				CSF_RPT_RUN: begin
					if (rpt_last) begin
						rpt_state_r <= CSF_RPT_IDLE; // RQ6
					end
				end
				default: rpt_state_r <= CSF_RPT_IDLE;
			endcase
		end
	end

	// repeat iteration counter
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			rpt_cnt_r <= 14'h0000;
		end else if (!rpt_running && rpt_start_i) begin
			rpt_cnt_r <= rpt_count_i;
		end else if (rpt_running && !rpt_last) begin
			rpt_cnt_r <= rpt_cnt_r - 14'h0001;
		end
	end

	// interrupt acceptance
	always_comb begin
		cpu_priority_o = {priority_extension_bit, cpu_priority_level_field}; // RQ3
		user_irq_disabled_o = priority_extension_bit || // RQ4
			field_at_max; // RQ2
		irq_accept_o = irq_pending_i && !user_irq_disabled_o && level_beats_field; // RQ12
		repeat_loop_active_o = rpt_running; // RQ6
	end

	// register read port, data stand one cycle after the strobe
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			rdata_r <= 16'h0000;
		end else if (rd_i) begin
			rdata_r <= read_word(addr_i, status_byte, core_ctrl_word, int_ctrl1_word);
		end else begin
			rdata_r <= 16'h0000;
		end
	end

	assign rdata_o = rdata_r;
endmodule // csf_status_flags
`default_nettype wire

// ==== test/csf_status_flags_properties.sv ====
// checker for the status flags low byte
// assumes a bind onto csf_status_flags
`include "csf_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module csf_sf_props
	import csf_pkg::*;
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [`CSF_ADDR_W-1:0] addr_i,
	input wire logic rd_i,
	input wire logic [15:0] rdata_o,
	input wire logic [15:0] op_a_i,
	input wire logic [15:0] op_b_i,
	input wire csf_op_t op_i,
	input wire logic [13:0] rpt_count_i,
	input wire logic rpt_start_i,
	input wire logic [2:0] irq_level_i,
	input wire logic irq_pending_i,
	input wire logic irq_accept_o,
	input wire logic [3:0] cpu_priority_o,
	input wire logic user_irq_disabled_o,
	input wire logic repeat_loop_active_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	logic [16:0] sum;
	assign sum = {1'b0, op_a_i} + {1'b0, op_b_i};
	sequence s_add;
		op_i == CSF_OP_ADD;
	endsequence
	sequence s_rd;
		rd_i && addr_i == `CSF_ADDR_STATUS && op_i == CSF_OP_NONE;
	endsequence
	a_ext_blocks: assert property (cpu_priority_o[3] |-> user_irq_disabled_o)
		else $error("ext bit set but irq enabled");
	a_lvl7_blocks: assert property (cpu_priority_o[2:0] == 3'h7 |-> user_irq_disabled_o)
		else $error("level 7 but irq enabled");
	a_no_accept: assert property (user_irq_disabled_o |-> !irq_accept_o)
		else $error("accept while disabled");
	a_accept_level: assert property (irq_accept_o |-> irq_pending_i && irq_level_i > cpu_priority_o[2:0])
		else $error("accept at wrong level");
	a_rpt_length: assert property (rpt_start_i && rpt_count_i == 14'h3 && !repeat_loop_active_o |=> repeat_loop_active_o [*4] ##1 !repeat_loop_active_o)
		else $error("repeat length wrong");
	a_prio_read: assert property (s_rd |=> rdata_o[7:5] == $past(cpu_priority_o[2:0]))
		else $error("priority field read wrong");
	a_neg_flag: assert property (s_add ##1 s_rd |=> rdata_o[3] == $past(sum[15], 2))
		else $error("negative flag wrong");
	a_ovf_flag: assert property (s_add ##1 s_rd |=> rdata_o[2] == $past(op_a_i[15] == op_b_i[15] && sum[15] != op_a_i[15], 2))
		else $error("overflow flag wrong");
	a_carry_flag: assert property (s_add ##1 s_rd |=> rdata_o[0] == $past(sum[16], 2))
		else $error("carry flag wrong");
	a_zero_flag: assert property (s_add ##1 s_rd |=> rdata_o[1] == $past(sum[15:0] == 16'h0000, 2))
		else $error("zero flag wrong");
	a_ra_read: assert property (s_rd |=> rdata_o[4] == $past(repeat_loop_active_o))
		else $error("repeat bit read wrong");
endmodule // csf_sf_props
`default_nettype wire

// ==== test/csf_irq_src.sv ====
// interrupt requester model
// assumes the block's clock and accept output
`timescale 1ns/1ns
`default_nettype none
module csf_irq_src (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic req_i,
	input wire logic [2:0] lvl_i,
	input wire logic accept_i,
	output logic pending_o,
	output logic [2:0] level_o
);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pending_o <= 1'b0;
			level_o <= 3'h0;
		end else if (req_i) begin
			pending_o <= 1'b1;
			level_o <= lvl_i;
		end else if (accept_i) begin
			pending_o <= 1'b0;
			level_o <= ~level_o;
		end
	end
endmodule // csf_irq_src
`default_nettype wire

// ==== test/csf_status_flags_test.sv ====
// bench for csf_status_flags
// assumes the checker and requester model are compiled first
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; $display("[ERR] %0t mismatch", $time); end end
module csf_status_flags_test
	import csf_pkg::*;
;
	logic clk_i = 0, sys_rst_i = 1, wr_i = 0, rd_i = 0, rpt_start_i = 0, pend, req = 0;
	logic exc_take = 0;
	logic [2:0] exc_lvl = 0;
	logic [3:0] nrun;
	logic [3:0] addr_i = 0, cpu_priority_o;
	logic [15:0] wdata_i = 0, op_a_i = 0, op_b_i = 0, rdata_o, rv;
	logic [13:0] rpt_count_i = 0;
	logic [2:0] lvl = 0, irq_level_i;
	logic irq_accept_o, user_irq_disabled_o, repeat_loop_active_o;
	csf_op_t op_i = CSF_OP_NONE;
	int err_total = 0, tests_run = 0;
	always #20 clk_i = ~clk_i;
	csf_status_flags dut (.clk_i, .sys_rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.op_a_i, .op_b_i, .op_i, .rpt_count_i, .rpt_start_i, .irq_level_i,
		.irq_pending_i(pend), .exc_level_i(exc_lvl), .exc_take_i(exc_take), .irq_accept_o,
		.cpu_priority_o, .user_irq_disabled_o, .repeat_loop_active_o);
	csf_irq_src peer (.clk_i, .rst_i(sys_rst_i), .req_i(req), .lvl_i(lvl),
		.accept_i(irq_accept_o), .pending_o(pend), .level_o(irq_level_i));
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		@(negedge clk_i);
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		op_i <= CSF_OP_NONE;
		@(negedge clk_i);
		rv = rdata_o;
	endtask
	task automatic alu(input csf_op_t o, input logic [15:0] a, input logic [15:0] b);
		@(posedge clk_i);
		op_i <= o;
		op_a_i <= a;
		op_b_i <= b;
		@(posedge clk_i);
		op_i <= CSF_OP_NONE;
		addr_i <= 4'h0;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		@(negedge clk_i);
		rv = rdata_o;
	endtask
	task automatic t_prio;
		wr(4'h0, 16'h00a0);
		rd(4'h0);
		`CHK(rv[7:5], 3'h5)
		`CHK(cpu_priority_o, 4'h5)
		wr(4'h1, 16'h0008);
		`CHK(cpu_priority_o, 4'hd)
		`CHK(user_irq_disabled_o, 1'b1)
		wr(4'h1, 16'h0000);
		wr(4'h0, 16'h00e0);
		`CHK(user_irq_disabled_o, 1'b1)
		wr(4'h2, 16'h8000);
		wr(4'h0, 16'h0040);
		rd(4'h0);
		`CHK(rv[7:5], 3'h7)
		@(posedge clk_i);
		exc_take <= 1'b1;
		exc_lvl <= 3'h6;
		@(posedge clk_i);
		exc_take <= 1'b0;
		@(negedge clk_i);
		`CHK(cpu_priority_o, 4'h6)
		wr(4'h2, 16'h0000);
	endtask
	task automatic t_irq;
		wr(4'h0, 16'h0060);
		@(posedge clk_i);
		req <= 1'b1;
		lvl <= 3'h3;
		@(posedge clk_i);
		req <= 1'b0;
		@(negedge clk_i);
		`CHK(irq_accept_o, 1'b0)
		wr(4'h0, 16'h0040);
		`CHK(irq_accept_o, 1'b1)
	endtask
	task automatic t_flags;
		alu(CSF_OP_ADD, 16'h7fff, 16'h0001);
		`CHK(rv[3:2], 2'h3)
		`CHK(rv[0], 1'b0)
		`CHK(rv[1], 1'b0)
		alu(CSF_OP_ADD, 16'hffff, 16'h0001);
		`CHK(rv[3:2], 2'h0)
		`CHK(rv[0], 1'b1)
		`CHK(rv[1], 1'b1)
		alu(CSF_OP_SUB, 16'h0005, 16'h0005);
		`CHK(rv[3:0], 4'h3)
		alu(CSF_OP_LOGIC, 16'h00f0, 16'h0f00);
		`CHK(rv[3:0], 4'h2)
		alu(CSF_OP_LOGIC, 16'h8000, 16'hffff);
		`CHK(rv[3:0], 4'h8)
		wr(4'h0, 16'h0008);
		rd(4'h0);
		`CHK(rv[3], 1'b1)
		wr(4'h0, 16'h0000);
		wr(4'h0, 16'h000f);
		rd(4'h0);
		`CHK(rv[3:0], 4'h0)
	endtask
	task automatic t_rpt;
		@(posedge clk_i);
		rpt_count_i <= 14'h3;
		rpt_start_i <= 1'b1;
		@(posedge clk_i);
		rpt_start_i <= 1'b0;
		nrun = 4'h0;
		repeat (8) @(negedge clk_i) nrun = nrun + {3'h0, repeat_loop_active_o};
		`CHK(nrun, 4'h4)
		@(posedge clk_i);
		rpt_count_i <= 14'h9;
		rpt_start_i <= 1'b1;
		@(posedge clk_i);
		rpt_start_i <= 1'b0;
		rd(4'h0);
		`CHK(rv[4], 1'b1)
		repeat (12) @(posedge clk_i);
		rd(4'h0);
		`CHK(rv[4], 1'b0)
	endtask
	task automatic t_reset;
		wr(4'h1, 16'h0008);
		@(posedge clk_i);
		sys_rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		@(negedge clk_i);
		`CHK(cpu_priority_o, 4'h0)
		rd(4'h0);
		`CHK(rv, 16'h0000)
	endtask
	task automatic close_out;
		$display("checks %0d errors %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		#100000;
		err_total++;
		close_out;
	end
	initial begin
		repeat (4) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		t_prio;
		t_irq;
		t_flags;
		t_rpt;
		t_reset;
		close_out;
	end
endmodule // csf_status_flags_test
bind csf_status_flags csf_sf_props u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
	.addr_i(addr_i), .rd_i(rd_i), .rdata_o(rdata_o), .op_a_i(op_a_i), .op_b_i(op_b_i),
	.op_i(op_i), .rpt_count_i(rpt_count_i), .rpt_start_i(rpt_start_i),
	.irq_level_i(irq_level_i), .irq_pending_i(irq_pending_i), .irq_accept_o(irq_accept_o),
	.cpu_priority_o(cpu_priority_o), .user_irq_disabled_o(user_irq_disabled_o),
	.repeat_loop_active_o(repeat_loop_active_o));
`default_nettype wire
